/* verilog/sdram_port_pkg.sv */
package sdram_port_pkg;

    // ==========================================================
    // Widths
    // ==========================================================
    localparam int DATA_W = 32;
    localparam int MASK_W = 4;
    localparam int ADDR_W = 12;
    localparam int BANK_W = 2;
    localparam int ROW_W = 12;
    localparam int COL_W = 8;
    localparam int WORD_ADDR_W = BANK_W + ROW_W + COL_W;
    localparam int WAIT_W = 14;
    localparam int FIFO_DEPTH = 4;
    localparam int FIFO_W = DATA_W + MASK_W;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_PERIOD_NS = 10;
    localparam int POWERUP_NS = 100000;
    localparam int T_RP_NS = 20;
    localparam int T_RCD_NS = 20;
    localparam int T_RFC_NS = 70;
    localparam int T_WR_NS = 15;
    localparam int T_REFI_NS = 7800;
    localparam int POWERUP_CYCLES = (POWERUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_RP_CYCLES = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_RCD_CYCLES = (T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_RFC_CYCLES = (T_RFC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_WR_CYCLES = (T_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_REFI_CYCLES = T_REFI_NS / CLK_PERIOD_NS;
    localparam int T_MRD_CYCLES = 2;
    localparam int CAS_LATENCY = 2;
    localparam int INIT_REFRESHES = 2;

    // ==========================================================
    // Commands as {cs_n, ras_n, cas_n, we_n}
    // ==========================================================
    localparam logic [3:0] CMD_NOP = 4'h7;
    localparam logic [3:0] CMD_ACTIVATE = 4'h3;
    localparam logic [3:0] CMD_READ = 4'h5;
    localparam logic [3:0] CMD_WRITE = 4'h4;
    localparam logic [3:0] CMD_PRECHARGE = 4'h2;
    localparam logic [3:0] CMD_REFRESH = 4'h1;
    localparam logic [3:0] CMD_MODE_WRITE = 4'h0;
    localparam logic [3:0] CMD_DESELECT = 4'hf;

    // Burst length 1, sequential, latency 2.
    localparam logic [ADDR_W-1:0] MODE_WORD = 12'h020;
    localparam int AUTO_PRECHARGE_BIT = 10;
    localparam logic [MASK_W-1:0] MASK_ALL = 4'hf;

    // ==========================================================
    // Queue sizing
    // ==========================================================
    localparam int TOTAL_FRAMES = 8192;
    localparam int MAX_FRAME_BYTES = 2016;
    localparam int TX_QUEUE_FRAMES = 4096;
    localparam int RX_QUEUE_FRAMES = TOTAL_FRAMES - TX_QUEUE_FRAMES;
    localparam int FRAME_CNT_W = 13;

    // ==========================================================
    // Sequencer states
    // ==========================================================
    typedef enum logic [10:0] {
        ST_POWERUP = 11'h001,
        ST_INIT_PRE = 11'h002,
        ST_INIT_REF = 11'h004,
        ST_INIT_MODE = 11'h008,
        ST_IDLE = 11'h010,
        ST_REFRESH = 11'h020,
        ST_ACTIVATE = 11'h040,
        ST_READ = 11'h080,
        ST_WRITE = 11'h100,
        ST_CAPTURE = 11'h200,
        ST_WAIT = 11'h400
    } seq_state_e;

endpackage

/* verilog/stream_fifo.sv */
module stream_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [CW-1:0] count, next_count;
    logic push, pop;

    // ==========================================================
    // Pointer and fill logic
    // ==========================================================
    always_comb begin
        push = in_valid && (count != FULL_COUNT);
        pop = out_ready && (count != '0);
        next_wr_ptr = push ? PW'((wr_ptr + 1'b1) % DEPTH) : wr_ptr;
        next_rd_ptr = pop ? PW'((rd_ptr + 1'b1) % DEPTH) : rd_ptr;
        next_count = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    assign in_ready = (count != FULL_COUNT);
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];

endmodule

/* verilog/queue_fill_monitor.sv */
module queue_fill_monitor #(
    parameter int CAPACITY = 4096,
    parameter int CNT_W = 13
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic push,
    input wire logic pop,
    input wire logic [CNT_W-1:0] high_watermark,
    output logic overflow,
    output logic high_reached
);

    localparam logic [CNT_W-1:0] CAP = CNT_W'(CAPACITY);

    logic [CNT_W-1:0] count, next_count;
    logic take, give;

    // ==========================================================
    // Frame count; a push into a full queue is lost and flagged
    // ==========================================================
    always_comb begin
        take = push && (count != CAP);
        give = pop && (count != '0);
        next_count = count;
        if (take && !give) begin
            next_count = count + 1'b1;
        end else if (give && !take) begin
            next_count = count - 1'b1;
        end
        overflow = push && (count == CAP);
        high_reached = (next_count != count) && (next_count == high_watermark);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

endmodule

/* verilog/sdram_queue_buffer_port.sv */
// What this block does
// R1: Data pins driven only while writing, sampled on reads, released otherwise.
// R2: Twelve address lines carry the row first, then the column of that access.
// R3: Row uses all twelve lines; column uses lines 0 to 9 and 11; this block puts the column on lines 0 to 7 and holds 8, 9 and 11 low.
// R4: Line 10 carries auto-precharge during column commands.
// R5: Two bank lines pick one of four banks for read, write, precharge.
// R6: Active-low row strobe forms activate, precharge and mode write commands.
// R7: Active-low column strobe latches the column as part of the command set.
// R8: Active-low write enable selects writes and precharge behaviour.
// R9: Four byte masks, high means write; mask 0 is bits 7..0.
// R10: Memory clock is a buffered copy of the system clock.
// R11: The board supplies a 100 MHz system clock for everything here.
// R12: Active-low chip select enables every memory access.
// R13: All memory sequencing runs by itself, with no software setup.
// R14: Overflow flag rises on queue overflow, falls on reaching high watermark.
// R15: Overflow flag behaves the same in every configuration mode.
// R16: Drives a 128 Mbit memory directly at up to 100 MHz.
// R17: Queues hold up to 8192 frames of at most 2016 bytes.
// R18: Mode write after reset, then periodic refresh, standard encodings.
module sdram_queue_buffer_port #(
    parameter int POWERUP_WAIT = sdram_port_pkg::POWERUP_CYCLES
) (
    input wire logic clk,
    input wire logic arst_n,
    output logic mem_clock_out,
    output logic mem_chip_select_n,
    output logic mem_row_strobe_n,
    output logic mem_col_strobe_n,
    output logic mem_write_enable_n,
    output logic [sdram_port_pkg::BANK_W-1:0] mem_bank_select,
    output logic [sdram_port_pkg::ADDR_W-1:0] mem_addr,
    output logic [sdram_port_pkg::MASK_W-1:0] mem_byte_write_mask,
    input wire logic [sdram_port_pkg::DATA_W-1:0] mem_data_bus_in,
    output logic [sdram_port_pkg::DATA_W-1:0] mem_data_bus_out,
    output logic mem_data_bus_oe,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_write,
    input wire logic [sdram_port_pkg::WORD_ADDR_W-1:0] cmd_addr,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [sdram_port_pkg::DATA_W-1:0] wr_data,
    input wire logic [sdram_port_pkg::MASK_W-1:0] wr_mask,
    output logic rd_valid,
    output logic [sdram_port_pkg::DATA_W-1:0] rd_data,
    output logic init_done,
    input wire logic tx_frame_push,
    input wire logic tx_frame_pop,
    input wire logic rx_frame_push,
    input wire logic rx_frame_pop,
    input wire logic [sdram_port_pkg::FRAME_CNT_W-1:0] tx_high_watermark,
    input wire logic [sdram_port_pkg::FRAME_CNT_W-1:0] rx_high_watermark,
    output logic queue_overflow_flag
);

    localparam int WW = sdram_port_pkg::WAIT_W;
    localparam int RW = $clog2(sdram_port_pkg::T_REFI_CYCLES + 1);
    localparam int DW = sdram_port_pkg::DATA_W;
    localparam int MW = sdram_port_pkg::MASK_W;
    localparam int AW = sdram_port_pkg::ADDR_W;

    // ==========================================================
    // Memory clock
    // ==========================================================
    // A flop cannot reproduce the clock at full rate, so the pin is
    // the clock net itself; commands change on the same edge. [R10] [R11] [R16]
    assign mem_clock_out = clk;

    // ==========================================================
    // Write data buffer
    // ==========================================================
    logic fifo_valid, fifo_pop;
    logic [sdram_port_pkg::FIFO_W-1:0] fifo_data;

    stream_fifo #(
        .WIDTH(sdram_port_pkg::FIFO_W),
        .DEPTH(sdram_port_pkg::FIFO_DEPTH)
    ) u_wr_fifo (
        .clk(clk),
        .arst_n(arst_n),
        .in_valid(wr_valid),
        .in_ready(wr_ready),
        .in_data({wr_mask, wr_data}),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    // ==========================================================
    // Queue overflow indication
    // ==========================================================
    logic tx_ovf, rx_ovf, tx_hw, rx_hw, next_ovf_flag;

    queue_fill_monitor #(
        .CAPACITY(sdram_port_pkg::TX_QUEUE_FRAMES),
        .CNT_W(sdram_port_pkg::FRAME_CNT_W)
    ) u_tx_queue (
        .clk(clk),
        .arst_n(arst_n),
        .push(tx_frame_push),
        .pop(tx_frame_pop),
        .high_watermark(tx_high_watermark),
        .overflow(tx_ovf),
        .high_reached(tx_hw)
    );

    queue_fill_monitor #(
        .CAPACITY(sdram_port_pkg::RX_QUEUE_FRAMES),
        .CNT_W(sdram_port_pkg::FRAME_CNT_W)
    ) u_rx_queue (
        .clk(clk),
        .arst_n(arst_n),
        .push(rx_frame_push),
        .pop(rx_frame_pop),
        .high_watermark(rx_high_watermark),
        .overflow(rx_ovf),
        .high_reached(rx_hw)
    );

    // No mode input reaches this flag, so every configuration acts alike. [R15]
    always_comb begin
        next_ovf_flag = queue_overflow_flag;
        if (tx_ovf || rx_ovf) begin
            next_ovf_flag = 1'b1; // [R14] [R17]
        end else if (tx_hw || rx_hw) begin
            next_ovf_flag = 1'b0; // [R14]
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            queue_overflow_flag <= 1'b0;
        end else begin
            queue_overflow_flag <= next_ovf_flag;
        end
    end

    // ==========================================================
    // Sequencer
    // ==========================================================
    sdram_port_pkg::seq_state_e state, next_state, ret, next_ret;
    logic [WW-1:0] wait_cnt, next_wait_cnt;
    logic [RW-1:0] refi_cnt, next_refi_cnt;
    logic ref_pend, next_ref_pend, refs_left, next_refs_left;
    logic op_write, next_op_write;
    logic [sdram_port_pkg::WORD_ADDR_W-1:0] op_addr, next_op_addr;
    logic [3:0] cmd, next_cmd;
    logic [sdram_port_pkg::BANK_W-1:0] next_bank;
    logic [AW-1:0] next_addr;
    logic [MW-1:0] next_mask;
    logic [DW-1:0] next_dq_out, next_rd_data;
    logic next_dq_oe, next_rd_valid, next_cmd_ready, next_init_done, accept;

    always_comb begin
        next_state = state;
        next_ret = ret;
        next_wait_cnt = wait_cnt;
        next_refs_left = refs_left;
        next_op_write = op_write;
        next_op_addr = op_addr;
        next_cmd = sdram_port_pkg::CMD_NOP;
        next_bank = mem_bank_select;
        next_addr = mem_addr;
        next_mask = sdram_port_pkg::MASK_ALL;
        next_dq_out = mem_data_bus_out;
        next_dq_oe = 1'b0; // [R1]
        next_rd_data = rd_data;
        next_rd_valid = 1'b0;
        next_init_done = init_done;
        fifo_pop = 1'b0;
        accept = 1'b0;

        // Refresh requests are sticky; a new tick wins over the clear. [R18]
        next_refi_cnt = refi_cnt - 1'b1;
        next_ref_pend = ref_pend;
        if (refi_cnt == '0) begin
            next_refi_cnt = RW'(sdram_port_pkg::T_REFI_CYCLES - 1);
        end

        // Every step runs from reset with no programming input. [R13]
        case (state)
            sdram_port_pkg::ST_POWERUP: begin
                if (wait_cnt <= WW'(1)) begin
                    next_state = sdram_port_pkg::ST_INIT_PRE;
                end else begin
                    next_wait_cnt = wait_cnt - 1'b1;
                end
            end
            sdram_port_pkg::ST_INIT_PRE: begin
                next_cmd = sdram_port_pkg::CMD_PRECHARGE; // [R6] [R12]
                next_addr[sdram_port_pkg::AUTO_PRECHARGE_BIT] = 1'b1;
                next_refs_left = 1'b1;
                next_state = sdram_port_pkg::ST_WAIT;
                next_wait_cnt = WW'(sdram_port_pkg::T_RP_CYCLES);
                next_ret = sdram_port_pkg::ST_INIT_REF;
            end
            sdram_port_pkg::ST_INIT_REF: begin
                next_cmd = sdram_port_pkg::CMD_REFRESH; // [R18]
                next_refs_left = 1'b0;
                next_state = sdram_port_pkg::ST_WAIT;
                next_wait_cnt = WW'(sdram_port_pkg::T_RFC_CYCLES);
                next_ret = refs_left ? sdram_port_pkg::ST_INIT_REF : sdram_port_pkg::ST_INIT_MODE;
            end
            sdram_port_pkg::ST_INIT_MODE: begin
                next_cmd = sdram_port_pkg::CMD_MODE_WRITE; // [R18] [R6]
                next_addr = sdram_port_pkg::MODE_WORD;
                next_bank = '0;
                next_state = sdram_port_pkg::ST_WAIT;
                next_wait_cnt = WW'(sdram_port_pkg::T_MRD_CYCLES);
                next_ret = sdram_port_pkg::ST_IDLE;
            end
            sdram_port_pkg::ST_IDLE: begin
                next_init_done = 1'b1;
                if (ref_pend) begin
                    next_state = sdram_port_pkg::ST_REFRESH;
                end else if (cmd_valid && cmd_ready && (!cmd_write || fifo_valid)) begin
                    accept = 1'b1;
                    next_op_write = cmd_write;
                    next_op_addr = cmd_addr;
                    next_state = sdram_port_pkg::ST_ACTIVATE;
                end
            end
            sdram_port_pkg::ST_REFRESH: begin
                next_cmd = sdram_port_pkg::CMD_REFRESH; // [R18]
                next_state = sdram_port_pkg::ST_WAIT;
                next_wait_cnt = WW'(sdram_port_pkg::T_RFC_CYCLES);
                next_ret = sdram_port_pkg::ST_IDLE;
            end
            sdram_port_pkg::ST_ACTIVATE: begin
                next_cmd = sdram_port_pkg::CMD_ACTIVATE; // [R6] [R12]
                next_bank = op_addr[21:20]; // [R5]
                next_addr = op_addr[19:8]; // [R2] [R3]
                next_state = sdram_port_pkg::ST_WAIT;
                next_wait_cnt = WW'(sdram_port_pkg::T_RCD_CYCLES);
                next_ret = op_write ? sdram_port_pkg::ST_WRITE : sdram_port_pkg::ST_READ;
            end
            sdram_port_pkg::ST_READ, sdram_port_pkg::ST_WRITE: begin
                // Column on lines 0..7, lines 8, 9 and 11 held low; line 10 asks for auto-precharge. [R3] [R4]
                next_addr = {1'b0, 1'b1, 2'b00, op_addr[7:0]}; // [R2]
                next_bank = op_addr[21:20]; // [R5]
                next_state = sdram_port_pkg::ST_WAIT;
                if (state == sdram_port_pkg::ST_WRITE) begin
                    next_cmd = sdram_port_pkg::CMD_WRITE; // [R7] [R8]
                    next_dq_out = fifo_data[DW-1:0];
                    next_dq_oe = 1'b1; // [R1]
                    next_mask = fifo_data[DW+MW-1:DW]; // [R9]
                    fifo_pop = 1'b1;
                    next_wait_cnt = WW'(sdram_port_pkg::T_WR_CYCLES + sdram_port_pkg::T_RP_CYCLES);
                    next_ret = sdram_port_pkg::ST_IDLE;
                end else begin
                    next_cmd = sdram_port_pkg::CMD_READ; // [R7]
                    next_wait_cnt = WW'(sdram_port_pkg::CAS_LATENCY);
                    next_ret = sdram_port_pkg::ST_CAPTURE;
                end
            end
            sdram_port_pkg::ST_CAPTURE: begin
                next_rd_data = mem_data_bus_in; // [R1]
                next_rd_valid = 1'b1;
                next_state = sdram_port_pkg::ST_WAIT;
                next_wait_cnt = WW'(sdram_port_pkg::T_RP_CYCLES);
                next_ret = sdram_port_pkg::ST_IDLE;
            end
            sdram_port_pkg::ST_WAIT: begin
                if (wait_cnt <= WW'(1)) begin
                    next_state = ret;
                end else begin
                    next_wait_cnt = wait_cnt - 1'b1;
                end
            end
            default: begin
                next_state = sdram_port_pkg::ST_POWERUP;
            end
        endcase

        if (next_cmd == sdram_port_pkg::CMD_REFRESH) begin
            next_ref_pend = 1'b0;
        end
        if (refi_cnt == '0) begin
            next_ref_pend = 1'b1;
        end
        next_cmd_ready = (next_state == sdram_port_pkg::ST_IDLE) && !next_ref_pend && !accept;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= sdram_port_pkg::ST_POWERUP;
            ret <= sdram_port_pkg::ST_IDLE;
            wait_cnt <= WW'(POWERUP_WAIT);
            refi_cnt <= RW'(sdram_port_pkg::T_REFI_CYCLES - 1);
            ref_pend <= 1'b0;
            refs_left <= 1'b0;
            op_write <= 1'b0;
            op_addr <= '0;
            cmd <= sdram_port_pkg::CMD_DESELECT;
            mem_bank_select <= '0;
            mem_addr <= '0;
            mem_byte_write_mask <= sdram_port_pkg::MASK_ALL;
            mem_data_bus_out <= '0;
            mem_data_bus_oe <= 1'b0;
            rd_data <= '0;
            rd_valid <= 1'b0;
            cmd_ready <= 1'b0;
            init_done <= 1'b0;
        end else begin
            state <= next_state;
            ret <= next_ret;
            wait_cnt <= next_wait_cnt;
            refi_cnt <= next_refi_cnt;
            ref_pend <= next_ref_pend;
            refs_left <= next_refs_left;
            op_write <= next_op_write;
            op_addr <= next_op_addr;
            cmd <= next_cmd;
            mem_bank_select <= next_bank;
            mem_addr <= next_addr;
            mem_byte_write_mask <= next_mask;
            mem_data_bus_out <= next_dq_out;
            mem_data_bus_oe <= next_dq_oe;
            rd_data <= next_rd_data;
            rd_valid <= next_rd_valid;
            cmd_ready <= next_cmd_ready;
            init_done <= next_init_done;
        end
    end

    // ==========================================================
    // Command pins
    // ==========================================================
    assign mem_chip_select_n = cmd[3]; // [R12]
    assign mem_row_strobe_n = cmd[2]; // [R6]
    assign mem_col_strobe_n = cmd[1]; // [R7]
    assign mem_write_enable_n = cmd[0]; // [R8]

endmodule

/* sim/sdram_port_checker_assertions.sv */
module sdram_port_checker (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic mem_chip_select_n,
    input wire logic mem_row_strobe_n,
    input wire logic mem_col_strobe_n,
    input wire logic mem_write_enable_n,
    input wire logic [sdram_port_pkg::BANK_W-1:0] mem_bank_select,
    input wire logic [sdram_port_pkg::ADDR_W-1:0] mem_addr,
    input wire logic [sdram_port_pkg::MASK_W-1:0] mem_byte_write_mask,
    input wire logic mem_data_bus_oe,
    input wire logic rd_valid,
    input wire logic init_done,
    input wire logic tx_frame_push,
    input wire logic rx_frame_push,
    input wire logic queue_overflow_flag
);
    // ==========
    // Command decode and refresh spacing.
    logic [3:0] cmd;
    int gap, next_gap;
    assign cmd = {mem_chip_select_n, mem_row_strobe_n, mem_col_strobe_n, mem_write_enable_n};
    always_comb begin
        next_gap = (cmd == sdram_port_pkg::CMD_REFRESH || !init_done) ? 0 : gap + 1;
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            gap <= 0;
        end else begin
            gap <= next_gap;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence s_act; cmd == sdram_port_pkg::CMD_ACTIVATE; endsequence
    sequence s_col; cmd == sdram_port_pkg::CMD_READ || cmd == sdram_port_pkg::CMD_WRITE; endsequence
    property p_oe_write; mem_data_bus_oe |-> cmd == sdram_port_pkg::CMD_WRITE; endproperty
    a_oe_write: assert property (p_oe_write) else $error("data bus driven outside write");
    property p_mask_idle; cmd != sdram_port_pkg::CMD_WRITE |-> mem_byte_write_mask == 4'hf; endproperty
    a_mask_idle: assert property (p_mask_idle) else $error("byte mask open outside write");
    property p_row_col; s_act |-> ##[1:4] s_col; endproperty
    a_row_col: assert property (p_row_col) else $error("no column after row");
    property p_col_a10; s_col |-> mem_addr[10] && mem_addr[9:8] == 2'h0; endproperty
    a_col_a10: assert property (p_col_a10) else $error("column address line 10 wrong");
    property p_rd; cmd == sdram_port_pkg::CMD_READ |-> ##3 rd_valid; endproperty
    a_rd: assert property (p_rd) else $error("read word not delivered");
    property p_mode; cmd == 4'h0 |-> mem_addr == 12'h020 && mem_bank_select == 2'h0; endproperty
    a_mode: assert property (p_mode) else $error("mode word wrong");
    property p_refresh; gap < 800; endproperty
    a_refresh: assert property (p_refresh) else $error("refresh overdue");
    property p_ovf; $rose(queue_overflow_flag) |-> $past(tx_frame_push || rx_frame_push); endproperty
    a_ovf: assert property (p_ovf) else $error("overflow flag without push");
endmodule

bind sdram_queue_buffer_port sdram_port_checker u_chk (.*);

/* sim/sdram_model.sv */
module sdram_model (
    input wire logic clk,
    input wire logic [3:0] cmd,
    input wire logic [1:0] ba,
    input wire logic [11:0] a,
    input wire logic [3:0] dqm,
    input wire logic [31:0] dq_in,
    output logic [31:0] dq_out = '0,
    output logic [24:0] last_loc
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========
    // Memory array, burst of one, read latency of two.
    logic [11:0] row [4] = '{default: '0};
    logic [31:0] mem [int];
    logic [31:0] pend = '0;
    logic [31:0] word;
    logic pv = 1'b0;
    int key;
    // Released data lines show the inverse of the last value, so a late capture cannot pass by luck.
    always @(posedge clk) begin
        key = {ba, row[ba], a[11], a[9:0]};
        word = mem.exists(key) ? mem[key] : '0;
        dq_out <= pv ? pend : ~dq_out;
        pv <= cmd == sdram_port_pkg::CMD_READ;
        pend <= word;
        if (cmd == sdram_port_pkg::CMD_ACTIVATE) begin
            row[ba] <= a;
        end
        if (cmd == sdram_port_pkg::CMD_WRITE) begin
            for (int b = 0; b < 4; b++) begin
                if (dqm[b]) begin
                    word[8*b+:8] = dq_in[8*b+:8];
                end
            end
            mem[key] = word;
            last_loc <= key[24:0];
        end
    end
endmodule

/* sim/tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic mem_clock_out, mem_chip_select_n, mem_row_strobe_n, mem_col_strobe_n, mem_write_enable_n;
    logic mem_data_bus_oe, cmd_ready, wr_ready, rd_valid, init_done, queue_overflow_flag;
    logic cmd_valid = 1'b0, cmd_write = 1'b0, wr_valid = 1'b0, tx_frame_push = 1'b0, rx_frame_push = 1'b0;
    logic tx_frame_pop = 1'b0, rx_frame_pop = 1'b0;
    logic [1:0] mem_bank_select;
    logic [11:0] mem_addr;
    logic [3:0] mem_byte_write_mask;
    logic [3:0] wr_mask = 4'hf;
    logic [31:0] mem_data_bus_in, mem_data_bus_out, rd_data, mdl_out;
    logic [31:0] wr_data = 32'h0000_0000;
    logic [21:0] cmd_addr = 22'h0_0000;
    logic [12:0] tx_high_watermark = 13'h0fff;
    logic [12:0] rx_high_watermark = 13'h0ffe;
    logic [24:0] last_loc;
    int n_fail = 0;
    int checks = 0;
    always #5 clk = ~clk;
    assign mem_data_bus_in = mem_data_bus_oe ? mem_data_bus_out : mdl_out;
    sdram_queue_buffer_port #(.POWERUP_WAIT(20)) DUT (.*);
    sdram_model mdl (
        .clk, .cmd({mem_chip_select_n, mem_row_strobe_n, mem_col_strobe_n, mem_write_enable_n}),
        .ba(mem_bank_select), .a(mem_addr), .dqm(mem_byte_write_mask), .dq_in(mem_data_bus_in),
        .dq_out(mdl_out), .last_loc
    );
    // ==========
    // Shared tasks.
    task automatic final_report;
        if (n_fail == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask
    function automatic logic sig(input int w);
        return w == 0 ? cmd_ready : (w == 1 ? rd_valid : init_done);
    endfunction
    task automatic wait_for(input int w);
        for (int i = 0; i < 2000 && sig(w) !== 1'b1; i++) begin
            @(negedge clk);
        end
        if (sig(w) !== 1'b1) begin
            n_fail++;
            final_report();
        end
    endtask
    task automatic access(input logic wr, input logic [21:0] a);
        @(negedge clk);
        cmd_write = wr;
        cmd_addr = a;
        cmd_valid = 1'b1;
        wait_for(0);
        @(negedge clk);
        cmd_valid = 1'b0;
    endtask
    // Fill the buffer, write three banks, read back with a masked merge.
    task automatic t_mem;
        logic [31:0] dw [4] = '{32'h1111_2222, 32'h3333_4444, 32'h5555_6666, 32'h7777_8888};
        logic [3:0] mk [4] = '{4'hf, 4'h6, 4'hf, 4'hf};
        logic [21:0] ad [4] = '{22'h0_0000, 22'h0_0000, 22'h1f_ffff, 22'h3a_5c3c};
        logic [31:0] ex [4] = '{32'h0000_0000, 32'h1133_4422, 32'h5555_6666, 32'h7777_8888};
        for (int i = 0; i < 4; i++) begin
            wr_data = dw[i];
            wr_mask = mk[i];
            wr_valid = 1'b1;
            @(negedge clk);
        end
        wr_valid = 1'b0;
        chk({31'h0, wr_ready}, 32'h0000_0000);
        for (int i = 0; i < 4; i++) begin
            access(1'b1, ad[i]);
        end
        wait_for(0);
        chk({7'h0, last_loc}, {7'h0, 2'h3, 12'ha5c, 11'h03c});
        chk({31'h0, wr_ready}, 32'h0000_0001);
        for (int i = 1; i < 4; i++) begin
            access(1'b0, ad[i]);
            wait_for(1);
            chk(rd_data, ex[i]);
        end
    endtask
    // Overfill one queue, then pop down to its watermark.
    task automatic t_queue(input logic rx);
        for (int i = 0; i < 4097; i++) begin
            tx_frame_push = !rx;
            rx_frame_push = rx;
            @(negedge clk);
        end
        tx_frame_push = 1'b0;
        rx_frame_push = 1'b0;
        for (int i = 0; i < (rx ? 2 : 1); i++) begin
            chk({31'h0, queue_overflow_flag}, 32'h0000_0001);
            tx_frame_pop = !rx;
            rx_frame_pop = rx;
            @(negedge clk);
            tx_frame_pop = 1'b0;
            rx_frame_pop = 1'b0;
            @(negedge clk);
        end
        chk({31'h0, queue_overflow_flag}, 32'h0000_0000);
    endtask
    initial begin
        repeat (16) @(negedge clk);
        arst_n = 1'b1;
        wait_for(2);
        chk({31'h0, mem_clock_out}, 32'h0000_0000);
        t_mem();
        t_queue(1'b0);
        t_queue(1'b1);
        final_report();
    end
endmodule
